// ---- rtl/awt_converter_ctl.sv ----
// Watchdog, alignment, sample timing and trigger control of the converter
// Functional notes
// - Threshold watch on routine results only while routine watch enable set.
// - Result above high or below low threshold sets the watch event flag.
// - Watch interrupt asserted only when its enable bit is set.
// - Thresholds compare against the raw result, before alignment.
// - Watch one selected channel or all channels, per single-channel bit.
// - Left alignment puts 12, 10 and 8 bit results at top of 16 bits.
// - Left alignment of 6 bit results fills the top of the low byte.
// - Each channel samples for its own 3-bit programmed cycle count.
// - 12-bit conversion lasts programmed sampling plus 12.5 cycles.
// - Rising edge of the selected trigger starts a routine conversion.
// - Trigger source codes select timers, external line, or software start.
// - With DMA enabled, one DMA request per completed routine conversion.
// - Internal channels bit powers temperature sensor and internal reference.
// - SAR phase is 12.5, 10.5, 8.5 or 6.5 cycles per resolution.
// - Minimum totals are 14, 12, 10 and 8 cycles per resolution.
// - Converter off holds the conversion logic in reset and powers analog down.
module awt_converter_ctl
  import awt_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic converter_on,
  input wire logic [1:0] resolution_select,
  input wire logic result_align_select,
  input wire logic [2:0] trigger_source_select,
  input wire logic software_routine_start,
  input wire logic adv_timer_compare_a,
  input wire logic adv_timer_compare_b,
  input wire logic adv_timer_compare_c,
  input wire logic gp_timer_trigger_out,
  input wire logic small_timer_compare_a,
  input wire logic external_line_eleven,
  input wire logic [4:0] routine_channel,
  input wire logic [CHANNELS*SAMPLE_FIELD_W-1:0] channel_sample_cycles,
  input wire logic routine_watch_enable,
  input wire logic watch_single_channel,
  input wire logic [4:0] watch_channel_select,
  input wire logic [RAW_W-1:0] watch_high_threshold,
  input wire logic [RAW_W-1:0] watch_low_threshold,
  input wire logic watch_event_irq_enable,
  input wire logic watch_event_clear,
  input wire logic dma_enable,
  input wire logic internal_channels_enable,
  input wire logic [RAW_W-1:0] conv_raw_data,
  output logic analog_power_on,
  output logic sensor_reference_on,
  output logic [4:0] conv_channel,
  output logic conv_sample,
  output logic conv_sar_run,
  output logic [RESULT_W-1:0] result_data,
  output logic result_valid,
  output logic dma_request,
  output logic watch_event_flag,
  output logic watch_irq,
  output logic busy
);
  // Sampling phase length for a 3-bit code
  function automatic logic [LEN_W-1:0] sample_len_of(
    input logic [SAMPLE_FIELD_W-1:0] code
  );
    sample_len_of = SAMPLE_MIN_CYCLES +
                    LEN_W'(SAMPLE_STEP_CYCLES * LEN_W'(code));
  endfunction : sample_len_of

  // SAR phase length for a resolution code
  function automatic logic [LEN_W-1:0] sar_len_of(input logic [1:0] res);
    case (res)
      RES_12: sar_len_of = SAR_CYCLES_12;
      RES_10: sar_len_of = SAR_CYCLES_10;
      RES_8: sar_len_of = SAR_CYCLES_8;
      default: sar_len_of = SAR_CYCLES_6;
    endcase
  endfunction : sar_len_of

  // Place a raw result according to resolution and alignment
  function automatic logic [RESULT_W-1:0] align_of(
    input logic [RAW_W-1:0] raw,
    input logic [1:0] res,
    input logic left
  );
    logic [RESULT_W-1:0] wide;
    wide = {{(RESULT_W-RAW_W){1'b0}}, raw};
    if (!left) begin
      align_of = wide;
    end else begin
      case (res)
        RES_12: align_of = wide << SHIFT_12;
        RES_10: align_of = wide << SHIFT_10;
        RES_8: align_of = wide << SHIFT_8;
        default: align_of = {8'h00, 8'(wide << SHIFT_6)};
      endcase
    end
  endfunction : align_of

  logic [5:0] trig_meta_reg;
  logic [5:0] trig_sync_reg;
  logic [5:0] trig_prev_reg;
  logic [1:0] res_reg;
  logic [4:0] chan_reg;
  logic sel_level;
  logic sel_prev;
  logic start_pulse;
  logic tmr_sampling;
  logic tmr_converting;
  logic tmr_done;
  logic logic_rst;
  logic [SAMPLE_FIELD_W-1:0] chan_code;
  logic [RAW_W-1:0] raw_masked;
  logic watch_hit;

  // Converter off acts as a reset of all conversion logic
  assign logic_rst = srst || !converter_on;

  // Two-stage synchronisers for the hardware trigger pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trig_meta_reg <= '0;
      trig_sync_reg <= '0;
      trig_prev_reg <= '0;
    end else if (clk_en) begin
      trig_meta_reg <= {external_line_eleven, small_timer_compare_a,
                        gp_timer_trigger_out, 1'b0, adv_timer_compare_c,
                        adv_timer_compare_b};
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  // Source select; compare_a has no vector slot, it uses the separate pair below
  logic adv_a_meta_reg;
  logic adv_a_sync_reg;
  logic adv_a_prev_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adv_a_meta_reg <= 1'b0;
      adv_a_sync_reg <= 1'b0;
      adv_a_prev_reg <= 1'b0;
    end else if (clk_en) begin
      adv_a_meta_reg <= adv_timer_compare_a;
      adv_a_sync_reg <= adv_a_meta_reg;
      adv_a_prev_reg <= adv_a_sync_reg;
    end
  end

  // Rising edge on the selected source, software start is a pulse
  always_comb begin
    sel_level = 1'b0;
    sel_prev = 1'b0;
    case (trigger_source_select)
      TRG_ADV_A: begin
        sel_level = adv_a_sync_reg;
        sel_prev = adv_a_prev_reg;
      end
      TRG_ADV_B: begin
        sel_level = trig_sync_reg[0];
        sel_prev = trig_prev_reg[0];
      end
      TRG_ADV_C: begin
        sel_level = trig_sync_reg[1];
        sel_prev = trig_prev_reg[1];
      end
      TRG_GP_OUT: begin
        sel_level = trig_sync_reg[3];
        sel_prev = trig_prev_reg[3];
      end
      TRG_SMALL_A: begin
        sel_level = trig_sync_reg[4];
        sel_prev = trig_prev_reg[4];
      end
      TRG_EXT_ELEVEN: begin
        sel_level = trig_sync_reg[5];
        sel_prev = trig_prev_reg[5];
      end
      TRG_SOFTWARE: begin
        sel_level = software_routine_start;
        sel_prev = 1'b0;
      end
      default: begin
        sel_level = 1'b0;
        sel_prev = 1'b0;
      end
    endcase
  end

  assign start_pulse = sel_level && !sel_prev && !busy;

  // Resolution is captured only while the converter is off
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      res_reg <= RES_12;
    end else if (clk_en && !converter_on) begin
      res_reg <= resolution_select;
    end
  end

  // Per-channel sample code lookup
  assign chan_code = (routine_channel < 5'(CHANNELS)) ?
    channel_sample_cycles[routine_channel*SAMPLE_FIELD_W +: SAMPLE_FIELD_W]
    : '0;

  awt_phase_timer u_timer (
    .clk_sys(clk_sys),
    .srst(logic_rst),
    .clk_en(clk_en),
    .start(start_pulse),
    .sample_len(sample_len_of(chan_code)),
    .sar_len(sar_len_of(res_reg)),
    .sampling(tmr_sampling),
    .converting(tmr_converting),
    .done(tmr_done)
  );

  // Channel and phase outputs towards the analog converter
  always_ff @(posedge clk_sys) begin
    if (logic_rst) begin
      chan_reg <= '0;
      busy <= 1'b0;
    end else if (clk_en) begin
      if (start_pulse) begin
        chan_reg <= routine_channel;
        busy <= 1'b1;
      end else if (tmr_done) begin
        busy <= 1'b0;
      end
    end
  end
  assign conv_channel = chan_reg;
  assign conv_sample = tmr_sampling;
  assign conv_sar_run = tmr_converting;

  // Power controls follow the enables
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      analog_power_on <= 1'b0;
      sensor_reference_on <= 1'b0;
    end else if (clk_en) begin
      analog_power_on <= converter_on;
      sensor_reference_on <= internal_channels_enable;
    end
  end

  // Raw result masked to the active resolution
  assign raw_masked = conv_raw_data &
    (RAW_W'({RAW_W{1'b1}}) >> (RAW_W'(res_reg) << 1));

  // Watch compare on the raw value of a monitored channel
  assign watch_hit = routine_watch_enable && tmr_done &&
    (!watch_single_channel || chan_reg == watch_channel_select) &&
    (raw_masked > watch_high_threshold ||
     raw_masked < watch_low_threshold);

  // Result register, valid and DMA strobes
  always_ff @(posedge clk_sys) begin
    if (logic_rst) begin
      result_data <= '0;
      result_valid <= 1'b0;
      dma_request <= 1'b0;
    end else if (clk_en) begin
      result_valid <= tmr_done;
      dma_request <= tmr_done && dma_enable;
      if (tmr_done) begin
        result_data <= align_of(raw_masked, res_reg, result_align_select);
      end
    end
  end

  // Sticky watch flag, a new event wins over a clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watch_event_flag <= 1'b0;
      watch_irq <= 1'b0;
    end else if (clk_en) begin
      if (watch_hit) begin
        watch_event_flag <= 1'b1;
      end else if (watch_event_clear) begin
        watch_event_flag <= 1'b0;
      end
      watch_irq <= (watch_hit || (watch_event_flag && !watch_event_clear))
                   && watch_event_irq_enable;
    end
  end
endmodule : awt_converter_ctl

// ---- rtl/awt_pkg.sv ----
// Package of constants and types for the converter control block
package awt_pkg;
  // Resolution field encodings
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;
  // Trigger source encodings
  localparam logic [2:0] TRG_ADV_A = 3'h0;
  localparam logic [2:0] TRG_ADV_B = 3'h1;
  localparam logic [2:0] TRG_ADV_C = 3'h2;
  localparam logic [2:0] TRG_RESERVED = 3'h3;
  localparam logic [2:0] TRG_GP_OUT = 3'h4;
  localparam logic [2:0] TRG_SMALL_A = 3'h5;
  localparam logic [2:0] TRG_EXT_ELEVEN = 3'h6;
  localparam logic [2:0] TRG_SOFTWARE = 3'h7;
  // Channel counts and widths
  localparam int NUM_CHANNELS = 18;
  localparam int SAMPLE_FIELD_W = 3;
  localparam int RAW_W = 12;
  localparam int RESULT_W = 16;
  localparam int LEN_W = 9;
  // Sampling phase: 1.5 cycles minimum held as 2 whole clock cycles,
  // SAR phase carries the other half cycle (12.5 -> 12 etc.)
  localparam logic [LEN_W-1:0] SAMPLE_MIN_CYCLES = 9'h002;
  localparam logic [LEN_W-1:0] SAMPLE_STEP_CYCLES = 9'h004;
  localparam logic [LEN_W-1:0] SAR_CYCLES_12 = 9'h00C;
  localparam logic [LEN_W-1:0] SAR_CYCLES_10 = 9'h00A;
  localparam logic [LEN_W-1:0] SAR_CYCLES_8 = 9'h008;
  localparam logic [LEN_W-1:0] SAR_CYCLES_6 = 9'h006;
  // Left-justify shift amounts
  localparam int SHIFT_12 = 4;
  localparam int SHIFT_10 = 6;
  localparam int SHIFT_8 = 8;
  localparam int SHIFT_6 = 2;
  // Phase timer states
  typedef enum logic [1:0] {AWT_IDLE, AWT_SAMPLE, AWT_SAR} awt_phase_t;
endpackage : awt_pkg

// ---- rtl/awt_phase_timer.sv ----
// Sampling and successive-approximation phase timer
module awt_phase_timer
  import awt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [LEN_W-1:0] sample_len,
  input wire logic [LEN_W-1:0] sar_len,
  output logic sampling,
  output logic converting,
  output logic done
);
  awt_phase_t state_reg;
  logic [LEN_W-1:0] count_reg;
  logic [LEN_W-1:0] sar_len_reg;

  // Phase sequence: sample window, then SAR steps, then one done pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= AWT_IDLE;
      count_reg <= '0;
      sar_len_reg <= '0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (state_reg)
        AWT_IDLE: begin
          if (start) begin
            state_reg <= AWT_SAMPLE;
            count_reg <= sample_len - 9'h001;
            sar_len_reg <= sar_len;
          end
        end
        AWT_SAMPLE: begin
          if (count_reg == '0) begin
            state_reg <= AWT_SAR;
            count_reg <= sar_len_reg - 9'h001;
          end else begin
            count_reg <= count_reg - 9'h001;
          end
        end
        AWT_SAR: begin
          if (count_reg == '0) begin
            state_reg <= AWT_IDLE;
            done <= 1'b1;
          end else begin
            count_reg <= count_reg - 9'h001;
          end
        end
        default: state_reg <= AWT_IDLE;
      endcase
    end
  end

  // Phase flags registered from state, count and start, in step with the next state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sampling <= 1'b0;
      converting <= 1'b0;
    end else if (clk_en) begin
      sampling <= (state_reg == AWT_IDLE && start) ||
                  (state_reg == AWT_SAMPLE && count_reg != '0);
      converting <= (state_reg == AWT_SAMPLE && count_reg == '0) ||
                    (state_reg == AWT_SAR && count_reg != '0);
    end
  end
endmodule : awt_phase_timer

// ---- verification/awt_far_model.sv ----
// Far side model: analog result source and DMA sink
module awt_far_model (
  input wire logic clk_sys,
  input wire logic conv_sar_run,
  input wire logic dma_request,
  input wire logic [15:0] result_data,
  input wire logic [11:0] raw_value,
  output logic [11:0] conv_raw_data,
  output logic [15:0] dma_word,
  output int dma_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sar_d = 1'b0;
  logic [11:0] junk = 12'h000;
  // Result is only valid during SAR and for one cycle after it, scrambled otherwise
  always @(posedge clk_sys) begin
    sar_d <= conv_sar_run;
    junk <= ~junk ^ 12'h5A5;
  end
  assign conv_raw_data = (conv_sar_run || sar_d) ? raw_value : junk;
  // Each request moves the current result to the destination
  initial dma_count = 0;
  always @(posedge clk_sys) begin
    if (dma_request) begin
      dma_word <= result_data;
      dma_count <= dma_count + 1;
    end
  end
endmodule : awt_far_model

// ---- verification/awt_props.sv ----
// Assertion checker for the converter control block
module awt_props
  import awt_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic converter_on,
  input wire logic [1:0] resolution_select,
  input wire logic [CHANNELS*SAMPLE_FIELD_W-1:0] channel_sample_cycles,
  input wire logic watch_event_irq_enable,
  input wire logic watch_event_clear,
  input wire logic dma_enable,
  input wire logic [4:0] conv_channel,
  input wire logic conv_sample,
  input wire logic conv_sar_run,
  input wire logic result_valid,
  input wire logic dma_request,
  input wire logic watch_event_flag,
  input wire logic watch_irq,
  input wire logic busy
);
  logic [2:0] code;
  logic [4:0] sar_run_len_reg;
  // Sample code of the channel being converted
  assign code = channel_sample_cycles[3*conv_channel +: 3];
  // Length of the current run of SAR cycles, saturating
  always_ff @(posedge clk_sys) begin
    if (srst || !conv_sar_run) begin
      sar_run_len_reg <= '0;
    end else if (sar_run_len_reg != 5'h1F) begin
      sar_run_len_reg <= sar_run_len_reg + 5'h01;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_dma_needs_valid: assert property (dma_request |-> result_valid)
    else $error("dma request without result");
  a_dma_when_on: assert property (
    result_valid && $past(dma_enable) |-> dma_request)
    else $error("missing dma request");
  a_valid_one_cycle: assert property (result_valid |=> !result_valid)
    else $error("result strobe too long");
  a_off_holds_idle: assert property (
    !converter_on ##1 !converter_on |-> !busy && !conv_sample
    && !conv_sar_run && !result_valid)
    else $error("conversion active while off");
  a_irq_needs_enable: assert property (
    watch_irq |-> $past(watch_event_irq_enable))
    else $error("irq without enable");
  a_flag_is_sticky: assert property (
    watch_event_flag && !watch_event_clear |=> watch_event_flag)
    else $error("watch flag lost");
  a_sar_twelve: assert property (
    $fell(conv_sar_run) && converter_on && resolution_select == RES_12
    |-> sar_run_len_reg == 5'h0C)
    else $error("12-bit SAR length wrong");
  a_sar_six: assert property (
    $rose(conv_sar_run) && resolution_select == RES_6
    |-> conv_sar_run [*6] ##1 !conv_sar_run)
    else $error("6-bit SAR length wrong");
  a_sample_min: assert property (
    $rose(conv_sample) && code == 3'h0
    |-> conv_sample [*2] ##1 (conv_sar_run && !conv_sample))
    else $error("minimum sampling length wrong");
  a_busy_covers: assert property ($rose(conv_sample) |-> busy)
    else $error("sampling while not busy");
  a_valid_after_sar: assert property (
    $fell(conv_sar_run) && converter_on |-> ##[1:2] result_valid)
    else $error("no result after SAR");
  c_dma: cover property (result_valid && dma_request);
  c_irq: cover property (watch_irq);
  c_six: cover property ($rose(conv_sar_run) && resolution_select == RES_6);
endmodule : awt_props
bind awt_converter_ctl awt_props #(.CHANNELS(CHANNELS)) i_awt_props (
  .clk_sys, .srst, .converter_on, .resolution_select,
  .channel_sample_cycles, .watch_event_irq_enable, .watch_event_clear,
  .dma_enable, .conv_channel, .conv_sample, .conv_sar_run, .result_valid,
  .dma_request, .watch_event_flag, .watch_irq, .busy);

// ---- verification/awt_converter_ctl_tb.sv ----
// Self-checking testbench for the converter control block
module awt_converter_ctl_tb
  import awt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic converter_on = 1'b0;
  logic [1:0] resolution_select = RES_12;
  logic result_align_select = 1'b0;
  logic [2:0] trigger_source_select = TRG_SOFTWARE;
  logic software_routine_start = 1'b0;
  logic [5:0] pins = 6'h00;
  logic [4:0] routine_channel = 5'h00;
  logic [53:0] channel_sample_cycles = 54'h0;
  logic routine_watch_enable = 1'b0;
  logic watch_single_channel = 1'b0;
  logic [4:0] watch_channel_select = 5'h00;
  logic [11:0] watch_high_threshold = 12'h800;
  logic [11:0] watch_low_threshold = 12'h100;
  logic watch_event_irq_enable = 1'b0;
  logic watch_event_clear = 1'b0;
  logic dma_enable = 1'b0;
  logic internal_channels_enable = 1'b0;
  logic [11:0] raw_value = 12'h000;
  logic [11:0] conv_raw_data;
  logic analog_power_on, sensor_reference_on, conv_sample, conv_sar_run;
  logic result_valid, dma_request, watch_event_flag, watch_irq, busy;
  logic [4:0] conv_channel;
  logic [15:0] result_data, dma_word, got;
  logic got_dma, got_flag, got_irq;
  int dma_count, n_samp, n_sar;
  int errors = 0;
  int compares = 0;
  // Free-running system clock
  always #4 clk_sys = ~clk_sys;
  awt_converter_ctl i_awt_converter_ctl (
    .clk_sys, .srst, .clk_en, .converter_on, .resolution_select,
    .result_align_select, .trigger_source_select, .software_routine_start,
    .adv_timer_compare_a(pins[0]), .adv_timer_compare_b(pins[1]),
    .adv_timer_compare_c(pins[2]), .gp_timer_trigger_out(pins[3]),
    .small_timer_compare_a(pins[4]), .external_line_eleven(pins[5]),
    .routine_channel, .channel_sample_cycles, .routine_watch_enable,
    .watch_single_channel, .watch_channel_select, .watch_high_threshold,
    .watch_low_threshold, .watch_event_irq_enable, .watch_event_clear,
    .dma_enable, .internal_channels_enable, .conv_raw_data,
    .analog_power_on, .sensor_reference_on, .conv_channel, .conv_sample,
    .conv_sar_run, .result_data, .result_valid, .dma_request,
    .watch_event_flag, .watch_irq, .busy);
  awt_far_model i_awt_far_model (.clk_sys, .conv_sar_run, .dma_request,
    .result_data, .raw_value, .conv_raw_data, .dma_word, .dma_count);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // Waits a bounded time for a result and counts the phase cycles
  task automatic wait_result(input logic expect_one);
    logic seen;
    seen = 1'b0;
    n_samp = 0;
    n_sar = 0;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(posedge clk_sys);
      software_routine_start <= 1'b0;
      #1;
      n_samp += conv_sample;
      n_sar += conv_sar_run;
      seen = result_valid;
      {got, got_dma, got_flag, got_irq} =
        {result_data, dma_request, watch_event_flag, watch_irq};
    end
    check(seen, expect_one);
  endtask : wait_result
  task automatic run(input logic [4:0] ch, input logic [11:0] raw);
    @(posedge clk_sys);
    routine_channel <= ch;
    raw_value <= raw;
    software_routine_start <= 1'b1;
    wait_result(1'b1);
  endtask : run
  task automatic set_res(input logic [1:0] r);
    @(posedge clk_sys);
    converter_on <= 1'b0;
    @(posedge clk_sys);
    resolution_select <= r;
    @(posedge clk_sys);
    converter_on <= 1'b1;
    @(posedge clk_sys);
  endtask : set_res
  task automatic test_format;
    logic [11:0] m;
    int w;
    for (int i = 0; i < 2; i++) begin
      run(5'(5 + i), 12'h123);
      check(16'(n_samp), 16'(2 + 4 * (i ? 1 : 7)));
      check(16'(n_samp + n_sar), 16'(12 + 2 + 4 * (i ? 1 : 7)));
    end
    for (int r = 0; r < 4; r++) begin
      for (int a = 0; a < 2; a++) begin
        set_res(r[1:0]);
        result_align_select <= a[0];
        run(5'h00, 12'hABC);
        w = 12 - 2 * r;
        m = 12'hABC & (12'hFFF >> (2 * r));
        check(got, a ? 16'(m) << ((r == 3) ? 8 - w : 16 - w) : 16'(m));
        check(16'(n_sar), 16'(w));
        check(16'(n_samp + n_sar), 16'(w + 2));
      end
    end
    $display("test_format done");
  endtask : test_format
  task automatic wcase(input logic en, sg, input logic [4:0] sel, ch,
    input logic [11:0] raw, input logic al, ie, ex);
    @(posedge clk_sys);
    routine_watch_enable <= en;
    watch_single_channel <= sg;
    watch_channel_select <= sel;
    result_align_select <= al;
    watch_event_irq_enable <= ie;
    dma_enable <= ie;
    run(ch, raw);
    check(got_flag, ex);
    check(got_irq, ex & ie);
    check(got_dma, ie);
    check(got, al ? {raw, 4'h0} : {4'h0, raw});
    @(posedge clk_sys);
    watch_event_clear <= 1'b1;
    #1;
    if (ie) check(dma_word, al ? {raw, 4'h0} : {4'h0, raw});
    @(posedge clk_sys);
    watch_event_clear <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(watch_event_flag, 1'b0);
  endtask : wcase
  task automatic test_watch;
    set_res(RES_12);
    wcase(0, 0, 5'h00, 5'h00, 12'hF00, 0, 1, 0);
    wcase(1, 0, 5'h00, 5'h00, 12'hF00, 0, 1, 1);
    wcase(1, 0, 5'h00, 5'h00, 12'h050, 0, 0, 1);
    wcase(1, 1, 5'h02, 5'h03, 12'hF00, 0, 0, 0);
    wcase(1, 1, 5'h03, 5'h03, 12'hF00, 0, 1, 1);
    wcase(1, 0, 5'h00, 5'h03, 12'h7F0, 1, 0, 0);
    wcase(1, 0, 5'h00, 5'h03, 12'h900, 1, 0, 1);
    check(16'(dma_count), 16'h0003);
    $display("test_watch done");
  endtask : test_watch
  task automatic test_trig;
    for (int s = 0; s < 7; s++) begin
      @(posedge clk_sys);
      trigger_source_select <= s[2:0];
      pins <= 6'h00;
      repeat (4) @(posedge clk_sys);
      pins <= (s == 3) ? 6'h3F : 6'h01 << ((s < 3) ? s : s - 1);
      wait_result(s != 3);
      if (s != 3) wait_result(1'b0);
    end
    @(posedge clk_sys);
    pins <= 6'h00;
    $display("test_trig done");
  endtask : test_trig
  // A frozen clock enable holds off a pending start until it returns
  task automatic test_freeze;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    trigger_source_select <= TRG_SOFTWARE;
    routine_channel <= 5'h00;
    software_routine_start <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    check(busy, 1'b0);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_result(1'b1);
    check(16'(n_samp + n_sar), 16'h000E);
    $display("test_freeze done");
  endtask : test_freeze
  task automatic test_power;
    @(posedge clk_sys);
    internal_channels_enable <= 1'b1;
    trigger_source_select <= TRG_SOFTWARE;
    routine_channel <= 5'h10;
    software_routine_start <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(sensor_reference_on, 1'b1);
    check(busy, 1'b1);
    check(conv_channel, 5'h10);
    check(analog_power_on, 1'b1);
    @(posedge clk_sys);
    converter_on <= 1'b0;
    internal_channels_enable <= 1'b0;
    wait_result(1'b0);
    check(analog_power_on, 1'b0);
    check(busy, 1'b0);
    check(sensor_reference_on, 1'b0);
    $display("test_power done");
  endtask : test_power
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    converter_on <= 1'b1;
    channel_sample_cycles[17:15] <= 3'h7;
    channel_sample_cycles[20:18] <= 3'h1;
    channel_sample_cycles[50:48] <= 3'h7;
    test_format;
    test_watch;
    test_trig;
    test_freeze;
    test_power;
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run;
  end
endmodule : awt_converter_ctl_tb
